/* hw/tdm_pkg.sv */
package tdm_pkg;
  // ----------------------------------------
  // Register indexes (low address nibble)
  // ----------------------------------------
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_HODO_DELAY = 4'h2;
  localparam logic [3:0] REG_FIBRE_DELAY = 4'h3;
  localparam logic [3:0] REG_FIBRE_WIDTH = 4'h4;
  localparam logic [3:0] REG_LUT_ADDR_LO = 4'h5;
  localparam logic [3:0] REG_LUT_ADDR_HI = 4'h6;
  localparam logic [3:0] REG_LUT_LEFT = 4'h7;
  localparam logic [3:0] REG_LUT_RIGHT = 4'h8;
  localparam logic [3:0] REG_LOADED = 4'h9;
  localparam logic [3:0] REG_NEXT = 4'hA;
  localparam logic [3:0] REG_RESULT = 4'hB;
  localparam logic [3:0] REG_TEST_CTRL = 4'hC;
  localparam logic [3:0] REG_TEST_ARM = 4'hD;
  localparam logic [3:0] REG_SCRATCH = 4'hF;
  // ----------------------------------------
  // Mode codes
  // ----------------------------------------
  localparam logic [3:0] MODE_IDLE = 4'h0;
  localparam logic [3:0] MODE_LOAD = 4'h1;
  localparam logic [3:0] MODE_WORK = 4'h2;
  localparam logic [3:0] MODE_SINGLE = 4'h3;
  localparam logic [3:0] MODE_TEST_TIMING = 4'h8;
  localparam logic [3:0] MODE_TEST_OVERALL = 4'h9;
  localparam logic [3:0] MODE_TEST_NEURAL = 4'hA;
  localparam logic [3:0] MODE_TEST_CONC = 4'hB;
  localparam logic [3:0] MODE_TEST_DECISION = 4'hC;
  localparam logic [3:0] MODE_TEST_BUS = 4'hD;
  // ----------------------------------------
  // Look-up table word layout
  // ----------------------------------------
  localparam int LUT_POS1_LSB = 0;
  localparam int LUT_POS2_LSB = 5;
  localparam int LUT_EMPTY_BIT = 10;
  localparam int LUT_OVR_BIT = 11;
  localparam int LUT_P1_VALID_BIT = 12;
  localparam int LUT_P2_VALID_BIT = 13;
  localparam int POS_W = 5;
  localparam int FIBRE_W = 16;
  localparam int WORD_W = 26;
  // ----------------------------------------
  // Reset values and limits
  // ----------------------------------------
  localparam logic [7:0] DELAY_RESET = 8'h19;
  localparam logic [7:0] WIDTH_RESET = 8'h28;
  localparam logic [5:0] FIBRE_OVR_LIMIT = 6'h05;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 100000;
  localparam int DELAY_STEP_PS = 500;
  localparam int FRONT_END_MIN_NS = 20;
  localparam int FRONT_END_MIN_CYC = (FRONT_END_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int NN_DELAY_NS = 6;
  localparam int DECISION_VALID_PULSE_DELAY_NS = 30;
  localparam int WATCHDOG_NS = 10000000;
  localparam int WATCHDOG_CYC = WATCHDOG_NS / (CLK_PERIOD_PS / 1000);
  typedef enum logic [2:0] {
    TDM_IDLE = 3'b001,
    TDM_RUN = 3'b010,
    TDM_HOLD = 3'b100
  } tdm_state_t;
endpackage

/* hw/tdm_master.sv */
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module tdm_master #(
  parameter int LUT_AW = 18,
  parameter int NN_DELAY_CYC = (tdm_pkg::NN_DELAY_NS * 1000 + tdm_pkg::CLK_PERIOD_PS - 1) / tdm_pkg::CLK_PERIOD_PS,
  parameter int DECISION_VALID_PULSE_DELAY_CYC = (tdm_pkg::DECISION_VALID_PULSE_DELAY_NS * 1000 + tdm_pkg::CLK_PERIOD_PS - 1)
    / tdm_pkg::CLK_PERIOD_PS,
  parameter int WATCHDOG_CYCLES = tdm_pkg::WATCHDOG_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic [15:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  output logic [15:0] bus_rdata_o,
  input wire logic [3:0] card_switch_i,
  input wire logic start_i,
  input wire logic inhibit_i,
  input wire logic [17:0] left_arm_hits_i,
  input wire logic [17:0] right_arm_hits_i,
  input wire logic [15:0] smallest_gap_inputs_i,
  input wire logic [15:0] hit_count_inputs_i,
  input wire logic [15:0] fibre_bus_i,
  input wire logic [3:0] neural_verdicts_i,
  output logic [3:0] concentrator_pick_o,
  output logic [103:0] neural_input_word_o,
  output logic [3:0] neural_card_clock_o,
  output logic hodo_latch_clock_o,
  output logic fibre_gate_o,
  output logic busy_o,
  output logic ready_o,
  output logic final_trigger_verdict_o,
  output logic decision_valid_pulse_o,
  output logic start_led_o,
  output logic busy_led_o,
  output logic loaded_led_o,
  output logic test_led_o,
  output logic load_led_o,
  output logic work_led_o,
  output logic single_led_o
);
  localparam int CW = 17;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Half-ns code to whole cycles, rounded up, never below one
  function automatic logic [CW-1:0] half_ns_to_cyc(input logic [7:0] code);
    int c;
    c = (int'(code) * tdm_pkg::DELAY_STEP_PS + tdm_pkg::CLK_PERIOD_PS - 1) / tdm_pkg::CLK_PERIOD_PS;
    if (c < 1) begin
      c = 1;
    end
    return c[CW-1:0];
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [3:0] mode_q;
  logic loaded_q;
  logic [7:0] hodo_delay_q;
  logic [7:0] fibre_gate_delay_q;
  logic [7:0] fibre_width_q;
  logic [LUT_AW-1:0] lut_addr_q;
  logic [1:0] test_ctrl_q;
  logic [9:0] test_arm_q;
  logic [15:0] scratch_q;
  logic [15:0] rdata_q;
  logic [3:0] card_q;
  logic start_q;
  tdm_pkg::tdm_state_t state_q;
  logic [CW-1:0] cnt_q;
  logic hodo_clk_q;
  logic gate_q;
  logic neural_card_clock_q;
  logic strobe_q;
  logic verdict_q;
  logic start_led_q;
  logic [17:0] hits_l_q;
  logic [17:0] hits_r_q;
  logic [15:0] lut_l_q;
  logic [15:0] lut_r_q;
  logic [3:0] pick_q;
  logic fibre_empty_q;
  logic fibre_ovr_q;
  logic [103:0] words_q;
  logic [14:0] result_q;
  logic [15:0] lut_left [0:(1<<LUT_AW)-1];
  logic [15:0] lut_right [0:(1<<LUT_AW)-1];

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire card_hit = bus_addr_i[7:4] == card_q;
  wire [3:0] reg_idx = bus_addr_i[3:0];
  wire wr_en = bus_wr_i && card_hit;
  wire rd_en = bus_rd_i && card_hit;
  // Zero-extended view keeps both address halves legal for any table depth
  wire [31:0] lut_addr_wide = 32'(lut_addr_q);
  wire wr_mode = wr_en && reg_idx == tdm_pkg::REG_MODE;
  wire wr_lut_l = wr_en && reg_idx == tdm_pkg::REG_LUT_LEFT && mode_q == tdm_pkg::MODE_LOAD;
  wire wr_lut_r = wr_en && reg_idx == tdm_pkg::REG_LUT_RIGHT && mode_q == tdm_pkg::MODE_LOAD;
  wire wr_next = wr_en && reg_idx == tdm_pkg::REG_NEXT;
  wire wr_test = wr_en && reg_idx == tdm_pkg::REG_TEST_CTRL;
  wire [3:0] req_mode = bus_wdata_i[3:0];
  wire req_operating = req_mode == tdm_pkg::MODE_WORK || req_mode == tdm_pkg::MODE_SINGLE;
  wire mode_accept = !req_operating || loaded_q;

  wire is_test = mode_q[3];
  wire is_work = mode_q == tdm_pkg::MODE_WORK;
  wire is_single = mode_q == tdm_pkg::MODE_SINGLE;
  wire is_test_timing = mode_q == tdm_pkg::MODE_TEST_TIMING;
  wire is_test_overall = mode_q == tdm_pkg::MODE_TEST_OVERALL;
  wire is_test_neural = mode_q == tdm_pkg::MODE_TEST_NEURAL;

  // ----------------------------------------
  // Start qualification
  // ----------------------------------------
  // A floating inhibit pin is pulled low at the pad, so low means inactive
  wire start_rise = start_i && !start_q;
  wire start_mode = is_work || is_single || is_test_overall
    || mode_q == tdm_pkg::MODE_TEST_CONC || mode_q == tdm_pkg::MODE_TEST_DECISION;
  wire ext_start = start_rise && start_mode && !inhibit_i;
  wire test_start = wr_test && is_test_timing && bus_wdata_i[0];
  wire in_idle = state_q == tdm_pkg::TDM_IDLE;
  wire in_hold = state_q == tdm_pkg::TDM_HOLD;
  wire accept = in_idle && (ext_start || test_start);

  // ----------------------------------------
  // Event schedule
  // ----------------------------------------
  wire [CW-1:0] hodo_at = half_ns_to_cyc(hodo_delay_q);
  wire [CW-1:0] gate_on = half_ns_to_cyc(fibre_gate_delay_q);
  wire [CW-1:0] gate_off = gate_on + half_ns_to_cyc(fibre_width_q);
  wire [CW-1:0] last_in = (hodo_at > gate_off) ? hodo_at : gate_off;
  wire [CW-1:0] nn_at = last_in + CW'(NN_DELAY_CYC);
  wire [CW-1:0] decision_valid_pulse_at = nn_at + CW'(DECISION_VALID_PULSE_DELAY_CYC);
  wire running = state_q == tdm_pkg::TDM_RUN;
  wire hodo_hit = running && cnt_q == hodo_at;
  wire gate_hit = running && cnt_q >= gate_on && cnt_q < gate_off;
  wire nn_hit = (running && cnt_q == nn_at) || (wr_test && is_test_timing && bus_wdata_i[1]);
  wire decision_valid_pulse_hit = running && cnt_q == decision_valid_pulse_at;
  // Watchdog bound keeps a lost sequence from blocking the trigger for good
  wire dog_hit = running && cnt_q >= CW'(WATCHDOG_CYCLES);

  // ----------------------------------------
  // Concentrator selection
  // ----------------------------------------
  wire [3:0] gap0 = smallest_gap_inputs_i[3:0];
  wire [3:0] gap1 = smallest_gap_inputs_i[7:4];
  wire [3:0] gap2 = smallest_gap_inputs_i[11:8];
  wire [3:0] gap3 = smallest_gap_inputs_i[15:12];
  wire [1:0] win01 = (gap1 < gap0) ? 2'h1 : 2'h0;
  wire [3:0] gap01 = (gap1 < gap0) ? gap1 : gap0;
  wire [1:0] win23 = (gap3 < gap2) ? 2'h3 : 2'h2;
  wire [3:0] gap23 = (gap3 < gap2) ? gap3 : gap2;
  // Ties go to the lower card number so the choice is always single
  wire [1:0] win = (gap23 < gap01) ? win23 : win01;
  wire [5:0] hit_sum = 6'(hit_count_inputs_i[3:0]) + 6'(hit_count_inputs_i[7:4])
    + 6'(hit_count_inputs_i[11:8]) + 6'(hit_count_inputs_i[15:12]);

  // ----------------------------------------
  // Arm positions and decision
  // ----------------------------------------
  wire [4:0] l_pos1 = is_test_neural ? test_arm_q[4:0] : lut_l_q[tdm_pkg::LUT_POS1_LSB +: tdm_pkg::POS_W];
  wire [4:0] l_pos2 = is_test_neural ? test_arm_q[4:0] : lut_l_q[tdm_pkg::LUT_POS2_LSB +: tdm_pkg::POS_W];
  wire [4:0] r_pos1 = is_test_neural ? test_arm_q[9:5] : lut_r_q[tdm_pkg::LUT_POS1_LSB +: tdm_pkg::POS_W];
  wire [4:0] r_pos2 = is_test_neural ? test_arm_q[9:5] : lut_r_q[tdm_pkg::LUT_POS2_LSB +: tdm_pkg::POS_W];
  wire left_arm_no_hit_flag = lut_l_q[tdm_pkg::LUT_EMPTY_BIT];
  wire right_arm_no_hit_flag = lut_r_q[tdm_pkg::LUT_EMPTY_BIT];
  wire left_arm_too_many_flag = lut_l_q[tdm_pkg::LUT_OVR_BIT];
  wire right_arm_too_many_flag = lut_r_q[tdm_pkg::LUT_OVR_BIT];
  wire [1:0] left_position_valid_flags = {lut_l_q[tdm_pkg::LUT_P2_VALID_BIT], lut_l_q[tdm_pkg::LUT_P1_VALID_BIT]};
  wire [1:0] right_position_valid_flags = {lut_r_q[tdm_pkg::LUT_P2_VALID_BIT], lut_r_q[tdm_pkg::LUT_P1_VALID_BIT]};
  wire any_empty = left_arm_no_hit_flag || right_arm_no_hit_flag || fibre_empty_q;
  wire any_ovr = left_arm_too_many_flag || right_arm_too_many_flag || fibre_ovr_q;
  wire nn_ok = (neural_verdicts_i[0] && left_position_valid_flags[0] && right_position_valid_flags[0])
    || (neural_verdicts_i[1] && left_position_valid_flags[0] && right_position_valid_flags[1])
    || (neural_verdicts_i[2] && left_position_valid_flags[1] && right_position_valid_flags[0])
    || (neural_verdicts_i[3] && left_position_valid_flags[1] && right_position_valid_flags[1]);
  wire decide = !any_empty && (any_ovr || nn_ok);
  wire [14:0] result_d = {pick_q, fibre_ovr_q, fibre_empty_q,
    left_position_valid_flags, left_arm_too_many_flag, left_arm_no_hit_flag,
    right_position_valid_flags, right_arm_too_many_flag, right_arm_no_hit_flag, decide};

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Data is zero outside the answer cycle of a read
  logic [15:0] rd_val;
  always_comb begin
    rd_val = 16'h0000;
    unique case (reg_idx)
      tdm_pkg::REG_MODE: rd_val = {12'h000, mode_q};
      tdm_pkg::REG_STATUS: rd_val = {8'h00, card_q, ready_o, busy_o, test_led_o, loaded_q};
      tdm_pkg::REG_HODO_DELAY: rd_val = {8'h00, hodo_delay_q};
      tdm_pkg::REG_FIBRE_DELAY: rd_val = {8'h00, fibre_gate_delay_q};
      tdm_pkg::REG_FIBRE_WIDTH: rd_val = {8'h00, fibre_width_q};
      tdm_pkg::REG_LUT_ADDR_LO: rd_val = lut_addr_wide[15:0];
      tdm_pkg::REG_LUT_ADDR_HI: rd_val = lut_addr_wide[31:16];
      tdm_pkg::REG_LUT_LEFT: rd_val = lut_l_q;
      tdm_pkg::REG_LUT_RIGHT: rd_val = lut_r_q;
      tdm_pkg::REG_RESULT: rd_val = {1'b0, result_q};
      tdm_pkg::REG_TEST_ARM: rd_val = {6'h00, test_arm_q};
      tdm_pkg::REG_SCRATCH: rd_val = scratch_q;
      default: rd_val = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // Bus side registers
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    card_q <= card_switch_i;
    rdata_q <= rd_en ? rd_val : 16'h0000;
    if (rst_i) begin
      mode_q <= tdm_pkg::MODE_IDLE;
      loaded_q <= 1'b0;
      hodo_delay_q <= tdm_pkg::DELAY_RESET;
      fibre_gate_delay_q <= tdm_pkg::DELAY_RESET;
      fibre_width_q <= tdm_pkg::WIDTH_RESET;
      lut_addr_q <= '0;
      test_arm_q <= 10'h000;
      scratch_q <= 16'h0000;
    end else if (wr_en) begin
      unique case (reg_idx)
        tdm_pkg::REG_MODE: begin
          if (mode_accept) begin
            mode_q <= req_mode;
          end
          if (req_mode == tdm_pkg::MODE_LOAD) begin
            loaded_q <= 1'b0; // Reloading invalidates the tables
          end
        end
        tdm_pkg::REG_HODO_DELAY: hodo_delay_q <= bus_wdata_i[7:0];
        tdm_pkg::REG_FIBRE_DELAY: fibre_gate_delay_q <= bus_wdata_i[7:0];
        tdm_pkg::REG_FIBRE_WIDTH: fibre_width_q <= bus_wdata_i[7:0];
        tdm_pkg::REG_LUT_ADDR_LO: lut_addr_q <= LUT_AW'({lut_addr_wide[31:16], bus_wdata_i});
        tdm_pkg::REG_LUT_ADDR_HI: lut_addr_q <= LUT_AW'({bus_wdata_i, lut_addr_wide[15:0]});
        tdm_pkg::REG_LUT_RIGHT: begin
          if (wr_lut_r) begin
            lut_addr_q <= lut_addr_q + 1'b1; // Sequential loading
          end
        end
        tdm_pkg::REG_LOADED: loaded_q <= bus_wdata_i[0];
        tdm_pkg::REG_TEST_ARM: test_arm_q <= bus_wdata_i[9:0];
        tdm_pkg::REG_SCRATCH: scratch_q <= bus_wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (wr_lut_l) begin
      lut_left[lut_addr_q] <= bus_wdata_i;
    end
    if (wr_lut_r) begin
      lut_right[lut_addr_q] <= bus_wdata_i;
    end
    lut_l_q <= lut_left[hits_l_q[LUT_AW-1:0]];
    lut_r_q <= lut_right[hits_r_q[LUT_AW-1:0]];
  end

  // ----------------------------------------
  // Timing unit
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    start_q <= start_i;
    if (rst_i) begin
      state_q <= tdm_pkg::TDM_IDLE;
      cnt_q <= '0;
      start_led_q <= 1'b0;
    end else begin
      start_led_q <= accept;
      unique case (state_q)
        tdm_pkg::TDM_IDLE: begin
          cnt_q <= '0;
          if (accept) begin
            state_q <= tdm_pkg::TDM_RUN;
          end
        end
        tdm_pkg::TDM_RUN: begin
          cnt_q <= cnt_q + 1'b1;
          if (dog_hit) begin
            state_q <= tdm_pkg::TDM_IDLE; // Watchdog frees a hung sequence
          end else if (decision_valid_pulse_hit) begin
            state_q <= is_single ? tdm_pkg::TDM_HOLD : tdm_pkg::TDM_IDLE;
          end
        end
        // Single shot parks here until software writes the release register or the mode leaves single shot
        tdm_pkg::TDM_HOLD: begin
          if (wr_next || !is_single) begin
            state_q <= tdm_pkg::TDM_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hodo_clk_q <= 1'b0;
      gate_q <= 1'b0;
      neural_card_clock_q <= 1'b0;
      strobe_q <= 1'b0;
      verdict_q <= 1'b0;
      result_q <= 15'h0000;
    end else begin
      hodo_clk_q <= hodo_hit;
      gate_q <= gate_hit;
      neural_card_clock_q <= nn_hit;
      strobe_q <= decision_valid_pulse_hit;
      if (decision_valid_pulse_hit) begin
        verdict_q <= decide;
        result_q <= result_d;
      end
    end
  end

  // ----------------------------------------
  // Pattern and selection datapath
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hits_l_q <= 18'h00000;
      hits_r_q <= 18'h00000;
      pick_q <= 4'h1;
      fibre_empty_q <= 1'b0;
      fibre_ovr_q <= 1'b0;
      words_q <= '0;
    end else begin
      if (hodo_hit) begin
        // Detector lines are only valid briefly, so they are caught once
        hits_l_q <= is_test_overall ? 18'(lut_addr_q) : left_arm_hits_i;
        hits_r_q <= is_test_overall ? 18'(lut_addr_q) : right_arm_hits_i;
      end
      pick_q <= 4'h1 << win;
      fibre_empty_q <= hit_sum == 6'h00;
      fibre_ovr_q <= hit_sum > tdm_pkg::FIBRE_OVR_LIMIT;
      words_q <= {fibre_bus_i, l_pos2, r_pos2, fibre_bus_i, l_pos2, r_pos1,
        fibre_bus_i, l_pos1, r_pos2, fibre_bus_i, l_pos1, r_pos1};
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus_rdata_o = rdata_q;
  assign concentrator_pick_o = pick_q;
  assign neural_input_word_o = words_q;
  assign neural_card_clock_o = {4{neural_card_clock_q}};
  assign hodo_latch_clock_o = hodo_clk_q;
  assign fibre_gate_o = gate_q;
  assign busy_o = !in_idle;
  assign ready_o = in_hold;
  assign final_trigger_verdict_o = verdict_q;
  assign decision_valid_pulse_o = strobe_q;
  assign start_led_o = start_led_q;
  assign busy_led_o = busy_o;
  assign loaded_led_o = loaded_q;
  assign test_led_o = is_test;
  assign load_led_o = mode_q == tdm_pkg::MODE_LOAD;
  assign work_led_o = is_work;
  assign single_led_o = is_single;
endmodule

/* verif/tdm_master_chk.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module tdm_master_chk (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic bus_rd_i,
  input wire logic [15:0] bus_rdata_o,
  input wire logic [3:0] concentrator_pick_o,
  input wire logic [3:0] neural_card_clock_o,
  input wire logic hodo_latch_clock_o,
  input wire logic fibre_gate_o,
  input wire logic busy_o,
  input wire logic final_trigger_verdict_o,
  input wire logic decision_valid_pulse_o,
  input wire logic start_led_o,
  input wire logic busy_led_o,
  input wire logic loaded_led_o,
  input wire logic test_led_o,
  input wire logic load_led_o,
  input wire logic work_led_o,
  input wire logic single_led_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_accept;
    start_led_o;
  endsequence
  // Holds only while the delay codes round to one cycle each
  sequence s_run;
    hodo_latch_clock_o && fibre_gate_o ##2 neural_card_clock_o == 4'hF ##1 decision_valid_pulse_o;
  endsequence
  a_event_order: assert property (s_accept |=> ##1 s_run)
    else $error("event steps out of order");
  a_pick_onehot: assert property ($onehot(concentrator_pick_o))
    else $error("pick not one-hot");
  a_busy_led: assert property (busy_led_o == busy_o)
    else $error("busy indicator differs from busy");
  a_start_busy: assert property (start_led_o |-> busy_o)
    else $error("start indicator without busy");
  a_start_ignored: assert property (start_led_o |=> !start_led_o [*4])
    else $error("start accepted while busy");
  a_strobe_width: assert property (decision_valid_pulse_o |=> !decision_valid_pulse_o)
    else $error("strobe longer than one cycle");
  a_verdict_hold: assert property (!decision_valid_pulse_o |-> $stable(final_trigger_verdict_o))
    else $error("verdict moved without strobe");
  a_gate_width: assert property ($rose(fibre_gate_o) |=> !fibre_gate_o)
    else $error("gate width wrong");
  a_nn_same: assert property (neural_card_clock_o == 4'h0 || neural_card_clock_o == 4'hF)
    else $error("neural clocks differ");
  a_rdata_idle: assert property (!$past(bus_rd_i) |-> bus_rdata_o == 16'h0000)
    else $error("read data outside read cycle");
  a_work_loaded: assert property ($rose(work_led_o) |-> loaded_led_o)
    else $error("work mode while not loaded");
  a_test_alone: assert property (test_led_o |-> !(work_led_o || load_led_o || single_led_o))
    else $error("test indicator with another mode");
endmodule
bind tdm_master tdm_master_chk i_chk (.core_clk_i, .rst_i, .bus_rd_i, .bus_rdata_o, .concentrator_pick_o,
  .neural_card_clock_o, .hodo_latch_clock_o, .fibre_gate_o, .busy_o, .final_trigger_verdict_o,
  .decision_valid_pulse_o, .start_led_o, .busy_led_o, .loaded_led_o, .test_led_o, .load_led_o, .work_led_o,
  .single_led_o);

/* verif/tdm_far_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Concentrator and neural cards
// ----------------------------------------
module tdm_far_model (
  input wire logic core_clk_i,
  input wire logic [3:0] concentrator_pick_i,
  input wire logic [15:0] gap_set_i,
  input wire logic [15:0] hit_set_i,
  input wire logic [3:0] verdict_set_i,
  output logic [15:0] smallest_gap_o,
  output logic [15:0] hit_count_o,
  output logic [15:0] fibre_bus_o,
  output logic [3:0] verdicts_o
);
  logic [15:0] float_q = 16'hA5A5;
  assign smallest_gap_o = gap_set_i;
  assign hit_count_o = hit_set_i;
  // Prompt neural answer, held for the whole event
  assign verdicts_o = verdict_set_i;
  // Undriven bus toggles so a stale value never looks valid
  always_comb begin
    fibre_bus_o = float_q;
    for (int n = 0; n < 4; n++) begin
      if (concentrator_pick_i == 4'(1 << n)) begin
        fibre_bus_o = {4'(n), 4'h1, 4'(n), 4'h2};
      end
    end
  end
  always_ff @(posedge core_clk_i) begin
    float_q <= ~float_q;
  end
endmodule

/* verif/tb_trigger_decision_master.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module tb_trigger_decision_master;
  localparam logic [3:0] SW = 4'hA;
  logic core_clk_i = 1'b0, rst_i = 1'b1, bus_wr_i = 1'b0, bus_rd_i = 1'b0, start_i = 1'b0, inhibit_i = 1'b0;
  logic [7:0] bus_addr_i = 8'h00;
  logic [15:0] bus_wdata_i = 16'h0000, gap_set = 16'hFFFF, hit_set = 16'h1111;
  logic [17:0] left_arm_hits_i = 18'h00000, right_arm_hits_i = 18'h00000;
  logic [3:0] nn_set = 4'h0;
  logic [15:0] bus_rdata_o, smallest_gap_inputs_i, hit_count_inputs_i, fibre_bus_i;
  logic [3:0] neural_verdicts_i, concentrator_pick_o;
  logic [103:0] neural_input_word_o;
  logic busy_o, ready_o, final_trigger_verdict_o, decision_valid_pulse_o, loaded_led_o, test_led_o, load_led_o;
  logic work_led_o, single_led_o;
  int mismatches = 0;
  int tests_run = 0;
  logic [15:0] gtab [3] = '{16'h1111, 16'h0FFF, 16'h3157};
  logic [3:0] ptab [3] = '{4'h1, 4'h8, 4'h4};
  logic [17:0] atab [4] = '{18'h00000, 18'h00001, 18'h00003, 18'h00007};
  always #50 core_clk_i = ~core_clk_i;
  tdm_master #(.LUT_AW(6), .WATCHDOG_CYCLES(200)) i_dut (
    .core_clk_i, .rst_i, .bus_addr_i, .bus_wdata_i, .bus_wr_i, .bus_rd_i, .bus_rdata_o, .card_switch_i(SW),
    .start_i, .inhibit_i, .left_arm_hits_i, .right_arm_hits_i, .smallest_gap_inputs_i, .hit_count_inputs_i,
    .fibre_bus_i, .neural_verdicts_i, .concentrator_pick_o, .neural_input_word_o, .neural_card_clock_o(),
    .hodo_latch_clock_o(), .fibre_gate_o(), .busy_o, .ready_o, .final_trigger_verdict_o, .decision_valid_pulse_o,
    .start_led_o(), .busy_led_o(), .loaded_led_o, .test_led_o, .load_led_o, .work_led_o, .single_led_o);
  tdm_far_model i_far (.core_clk_i, .concentrator_pick_i(concentrator_pick_o), .gap_set_i(gap_set),
    .hit_set_i(hit_set), .verdict_set_i(nn_set), .smallest_gap_o(smallest_gap_inputs_i),
    .hit_count_o(hit_count_inputs_i), .fibre_bus_o(fibre_bus_i), .verdicts_o(neural_verdicts_i));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lut(input logic [17:0] h);
    case (h)
      18'h00000: return 16'h0400;
      18'h00001: return 16'h1001;
      18'h00003: return 16'h3041;
      default: return 16'h0800;
    endcase
  endfunction
  task automatic close_out;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] idx, input logic [15:0] d);
    @(posedge core_clk_i);
    bus_addr_i <= {SW, idx};
    bus_wdata_i <= d;
    bus_wr_i <= 1'b1;
    @(posedge core_clk_i);
    bus_wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk_i);
    bus_addr_i <= a;
    bus_rd_i <= 1'b1;
    @(posedge core_clk_i);
    bus_rd_i <= 1'b0;
    #1;
    `CHK(bus_rdata_o, exp)
  endtask
  task automatic ev(input logic [17:0] l, input logic [17:0] r, input logic [3:0] nn, input logic v);
    logic [15:0] lw, rw, f;
    int n;
    lw = lut(l);
    rw = lut(r);
    f = 16'h2122;
    n = 0;
    @(posedge core_clk_i);
    start_i <= 1'b1;
    nn_set <= nn;
    @(posedge core_clk_i);
    left_arm_hits_i <= l;
    right_arm_hits_i <= r;
    #1;
    while (decision_valid_pulse_o !== 1'b1) begin
      @(posedge core_clk_i);
      #1;
      n++;
      if (n > 30) begin
        $display("[FAIL] %0t strobe timeout", $time);
        mismatches++;
        close_out();
      end
    end
    `CHK(final_trigger_verdict_o, v)
    `CHK(neural_input_word_o, {f, lw[9:5], rw[9:5], f, lw[9:5], rw[4:0], f, lw[4:0], rw[9:5], f, lw[4:0], rw[4:0]})
    @(posedge core_clk_i);
    start_i <= 1'b0;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd_chk({SW, 4'h1}, {8'h00, SW, 4'h0});
    rd_chk({SW, 4'h2}, 16'h0019);
    rd_chk({SW, 4'h4}, 16'h0028);
    rd_chk({SW, 4'hE}, 16'h0000);
    rd_chk({~SW, 4'h2}, 16'h0000);
    wr_reg(4'h0, 16'h0002);
    rd_chk({SW, 4'h0}, 16'h0000);
    wr_reg(4'h0, 16'h0001);
    #1;
    `CHK(load_led_o, 1'b1)
    wr_reg(4'h6, 16'h0000);
    foreach (atab[i]) begin
      wr_reg(4'h5, atab[i][15:0]);
      wr_reg(4'h7, lut(atab[i]));
      wr_reg(4'h8, lut(atab[i]));
    end
    wr_reg(4'h9, 16'h0001);
    rd_chk({SW, 4'h1}, {8'h00, SW, 4'h1});
    wr_reg(4'h0, 16'h0002);
    #1;
    `CHK(work_led_o, 1'b1)
    foreach (gtab[i]) begin
      @(posedge core_clk_i);
      gap_set <= gtab[i];
      repeat (3) @(posedge core_clk_i);
      #1;
      `CHK(concentrator_pick_o, ptab[i])
    end
    @(posedge core_clk_i);
    inhibit_i <= 1'b1;
    @(posedge core_clk_i);
    start_i <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    #1;
    `CHK(busy_o, 1'b0)
    @(posedge core_clk_i);
    start_i <= 1'b0;
    inhibit_i <= 1'b0;
    ev(18'h00003, 18'h00001, 4'h0, 1'b0);
    ev(18'h00003, 18'h00001, 4'h1, 1'b1);
    ev(18'h00003, 18'h00001, 4'h8, 1'b0);
    ev(18'h00007, 18'h00001, 4'h0, 1'b1);
    ev(18'h00007, 18'h00000, 4'h0, 1'b0);
    wr_reg(4'h0, 16'h0003);
    #1;
    `CHK(single_led_o, 1'b1)
    ev(18'h00003, 18'h00001, 4'h1, 1'b1);
    #1;
    `CHK(ready_o, 1'b1)
    wr_reg(4'hA, 16'h0001);
    #1;
    `CHK(ready_o, 1'b0)
    for (int m = 8; m < 14; m++) begin
      wr_reg(4'h0, 16'(m));
      #1;
      `CHK(test_led_o, 1'b1)
    end
    wr_reg(4'h0, 16'h0008);
    wr_reg(4'hC, 16'h0001);
    #1;
    `CHK(busy_o, 1'b1)
    wr_reg(4'h0, 16'h0000);
    close_out();
  end
endmodule
